/* File: src/tcc_pkg.sv */
// Package for the transmit and clock control register block.
// Assumes an 8-bit register reached by SPI opcode strobes decoded elsewhere.
package tcc_pkg;

  // ==========================================================================
  // Register field positions and reset values
  localparam int          TCC_BIT_SEND_GATE    = 7;
  localparam int          TCC_BIT_SINGLE_MSG   = 6;
  localparam int          TCC_BIT_NO_RETRY     = 5;
  localparam int          TCC_BIT_ID_FILTER    = 4;
  localparam int          TCC_BIT_XTAL_OFF     = 3;
  localparam int          TCC_BIT_SPARE        = 2;
  localparam int          TCC_DIV_LSB          = 0;
  localparam logic [7:0]  TCC_CTRL_RESET       = 8'h00;
  localparam logic [2:0]  TCC_MODE_RESET       = 3'h4;
  localparam int          TCC_MODE_INIT_BIT    = 2;
  localparam logic [2:0]  TCC_DIV_CNT_RESET    = 3'h0;

  // ==========================================================================
  // Packed register image.
  typedef struct packed {
    logic       send_gate;
    logic       single_message_send;
    logic       no_retry_mode;
    logic       id_filter_enable;
    logic       crystal_drive_disable;
    logic       spare;
    logic [1:0] clock_output_divider;
  } tcc_ctrl_t;

  // Handshake with the transmit engine.
  typedef struct packed {
    logic fifo_empty;   // Transmit FIFO holds no message.
    logic bus_free;     // Bus idle, a frame may start.
    logic tx_started;   // Pulse: frame start of field sent.
    logic tx_done_ok;   // Pulse: frame sent and acknowledged.
    logic tx_failed;    // Pulse: arbitration lost or error.
  } tcc_eng_status_t;

  typedef struct packed {
    logic load_next;    // Pulse: move next FIFO message and start.
    logic allow_retry;  // Engine may retransmit after a failure.
  } tcc_eng_cmd_t;

endpackage : tcc_pkg

/* File: src/tcc_clock_divider.sv */
// Clock output divider for the divided clock pin.
// Assumes the system clock is the source to be divided.
`timescale 1ns/1ns
module tcc_clock_divider (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // Divider select
  input  wire logic [1:0] div_sel,
  // Divided clock, registered except at divide by one, where the clock passes through
  output logic            divided_clock_pin
);
  import tcc_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic       out;
  } tcc_div_state_t;

  tcc_div_state_t state_ff;
  tcc_div_state_t nxt_state;

  // ==========================================================================
  // Divide by one passes the clock level; divide by two toggles every cycle, longer ratios on count.
  always_comb begin
    nxt_state = state_ff;
    case (div_sel)
      2'h0: begin
        nxt_state.out = ~state_ff.out; // Register toggles each cycle, but the pin passes the clock itself.
        nxt_state.cnt = TCC_DIV_CNT_RESET;
      end
      2'h1: begin
        nxt_state.out = ~state_ff.out;
        nxt_state.cnt = TCC_DIV_CNT_RESET;
      end
      2'h2: begin
        nxt_state.cnt = state_ff.cnt + 3'h1;
        if (state_ff.cnt[0]) begin
          nxt_state.out = ~state_ff.out;
          nxt_state.cnt = TCC_DIV_CNT_RESET;
        end
      end
      default: begin
        nxt_state.cnt = state_ff.cnt + 3'h1;
        if (state_ff.cnt[1:0] == 2'h3) begin
          nxt_state.out = ~state_ff.out;
          nxt_state.cnt = TCC_DIV_CNT_RESET;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Divide by one cannot come from a flip-flop; pass the clock through.
  assign divided_clock_pin = (div_sel == 2'h0) ? clock : state_ff.out;

endmodule : tcc_clock_divider

/* File: src/tcc_ctrl.sv */
// Transmit and clock control register with transmit gating logic.
// Assumes SPI opcode decode yields write and read strobes, and a transmit
// engine that reports frame start, success and failure as pulses.
`timescale 1ns/1ns

// What this block does
// - Send enable is register bit OR pin.
// - Enabled: send queued messages until FIFO empty.
// - Pin drop mid-frame: finish, then hold.
// - Single bit sends just one message.
// - Single bit self-clears on success, or on start in no-retry mode.
// - No-retry mode with single bit: one attempt, no retransmission.
// - Unsent message stays queued; host clears FIFO.
// - Filter bit enables identifier acceptance filtering.
// - Bit 3 shuts off crystal drive pin.
// - Divider codes give 1, 2, 4, 8.
// - Mode top bit set means initialization.
module tcc_ctrl (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  // Register access from the SPI decoder
  input  wire logic                     ctrl_wr,
  input  wire logic [7:0]               ctrl_wdata,
  output logic [7:0]                    ctrl_rdata,
  // Operating mode select from the mode register
  input  wire logic [2:0]               operating_mode_select,
  // External send gate pin
  input  wire logic                     send_gate_pin,
  // Transmit engine handshake
  input  wire tcc_pkg::tcc_eng_status_t eng_status,
  output tcc_pkg::tcc_eng_cmd_t         eng_cmd,
  // Receive path and pins
  output logic                          id_filter_active,
  output logic                          crystal_drive_enable,
  output logic                          init_mode,
  output logic                          divided_clock_pin
);
  import tcc_pkg::*;

  typedef enum logic [1:0] {
    TCC_IDLE,
    TCC_WAIT_START,
    TCC_SENDING
  } tcc_tx_state_t;

  typedef struct packed {
    tcc_ctrl_t     ctrl;
    tcc_tx_state_t tx;
    logic          single_shot;  // Current frame was released by the single bit.
    logic          oneshot;      // Current frame must not be retried.
    logic          load_next;
    logic          allow_retry;
    logic          filt;
    logic          xtal_en;
    logic          init;
    logic [7:0]    rdata;
  } tcc_state_t;

  tcc_state_t state_ff;
  tcc_state_t nxt_state;
  logic       send_enable;
  logic       div_clk;

  // ==========================================================================
  // Effective send enable.
  // bit OR pin
  assign send_enable = state_ff.ctrl.send_gate | send_gate_pin;

  // ==========================================================================
  // Next-state logic. Hardware clears of the single bit are applied after the
  // host write, so an in-flight completion is never lost to a late write.
  always_comb begin
    nxt_state           = state_ff;
    nxt_state.load_next = 1'b0;
    if (ctrl_wr) begin
      nxt_state.ctrl = tcc_ctrl_t'(ctrl_wdata);
    end
    case (state_ff.tx)
      TCC_IDLE: begin
        if (!eng_status.fifo_empty && eng_status.bus_free) begin
          if (send_enable) begin
            nxt_state.load_next   = 1'b1;
            nxt_state.single_shot = 1'b0;
            nxt_state.oneshot     = 1'b0;
            nxt_state.allow_retry = 1'b1;
            nxt_state.tx          = TCC_WAIT_START;
          end else if (state_ff.ctrl.single_message_send) begin
            nxt_state.load_next   = 1'b1;
            nxt_state.single_shot = 1'b1;
            nxt_state.oneshot     = state_ff.ctrl.no_retry_mode;
            nxt_state.allow_retry = ~state_ff.ctrl.no_retry_mode;
            nxt_state.tx          = TCC_WAIT_START;
          end
        end
      end
      TCC_WAIT_START: begin
        if (eng_status.tx_started) begin
          nxt_state.tx = TCC_SENDING;
          if (state_ff.oneshot) begin
            nxt_state.ctrl.single_message_send = 1'b0;
          end
        end
      end
      default: begin
        // finish current frame, then recheck gate
        if (eng_status.tx_done_ok) begin
          nxt_state.tx = TCC_IDLE;
          if (state_ff.single_shot) begin
            nxt_state.ctrl.single_message_send = 1'b0;
          end
        end else if (eng_status.tx_failed) begin
          if (state_ff.oneshot) begin
            nxt_state.tx = TCC_IDLE;
          end else begin
            nxt_state.tx = TCC_WAIT_START;
          end
        end
      end
    endcase
    if (state_ff.tx == TCC_IDLE) begin
      nxt_state.allow_retry = nxt_state.tx != TCC_IDLE ? nxt_state.allow_retry : 1'b1;
    end
    nxt_state.filt    = nxt_state.ctrl.id_filter_enable;
    nxt_state.xtal_en = ~nxt_state.ctrl.crystal_drive_disable;
    nxt_state.init    = operating_mode_select[TCC_MODE_INIT_BIT];
    nxt_state.rdata   = nxt_state.ctrl;
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff.ctrl        <= tcc_ctrl_t'(TCC_CTRL_RESET);
      state_ff.tx          <= TCC_IDLE;
      state_ff.single_shot <= 1'b0;
      state_ff.oneshot     <= 1'b0;
      state_ff.load_next   <= 1'b0;
      state_ff.allow_retry <= 1'b1;
      state_ff.filt        <= 1'b0;
      state_ff.xtal_en     <= 1'b1;
      state_ff.init        <= TCC_MODE_RESET[TCC_MODE_INIT_BIT];
      state_ff.rdata       <= TCC_CTRL_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // Divided clock output.
  tcc_clock_divider u_div (
    .clock             (clock),
    .rst_b             (rst_b),
    .div_sel           (state_ff.ctrl.clock_output_divider),
    .divided_clock_pin (div_clk)
  );

  assign ctrl_rdata            = state_ff.rdata;
  assign eng_cmd.load_next     = state_ff.load_next;
  assign eng_cmd.allow_retry   = state_ff.allow_retry;
  assign id_filter_active      = state_ff.filt;
  assign crystal_drive_enable  = state_ff.xtal_en;
  assign init_mode             = state_ff.init;
  // The divider output is a clock, not a state bit; it is passed straight out.
  assign divided_clock_pin     = div_clk;

endmodule : tcc_ctrl

/* File: dv/tcc_monitor.sv */
// Checker for the transmit and clock control register ports.
// Assumes it is bound to tcc_ctrl and sees only its ports.
`timescale 1ns/1ns
module tcc_monitor (
  // Clock and reset
  input wire logic                     clock,
  input wire logic                     rst_b,
  // Register access, mode and pin
  input wire logic                     ctrl_wr,
  input wire logic [7:0]               ctrl_wdata,
  input wire logic [7:0]               ctrl_rdata,
  input wire logic [2:0]               operating_mode_select,
  input wire logic                     send_gate_pin,
  // Engine handshake and outputs
  input wire tcc_pkg::tcc_eng_status_t eng_status,
  input wire tcc_pkg::tcc_eng_cmd_t    eng_cmd,
  input wire logic                     id_filter_active,
  input wire logic                     crystal_drive_enable,
  input wire logic                     init_mode
);
  import tcc_pkg::*;
  logic [7:0] last_wr_ff;
  logic       gate_on;
  // Keep the last written byte, since bit 6 may be cleared by hardware.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) last_wr_ff <= 8'h00;
    else if (ctrl_wr) last_wr_ff <= ctrl_wdata;
  end
  assign gate_on = ctrl_rdata[7] | ctrl_rdata[6] | send_gate_pin;
  // ==========================================================================
  // Properties
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_one_shot_go;
    eng_status.tx_started && ctrl_rdata[6:5] == 2'h3 && !ctrl_rdata[7] && !send_gate_pin;
  endsequence
  AST_FILTER_BIT: assert property ($fell(ctrl_wr) |=> id_filter_active == last_wr_ff[4])
    else $error("filter output differs from bit 4");
  AST_XTAL_BIT: assert property ($fell(ctrl_wr) |=> crystal_drive_enable == !last_wr_ff[3])
    else $error("crystal drive differs from bit 3");
  AST_READBACK: assert property ($fell(ctrl_wr) |=> (ctrl_rdata & 8'hbf) == (last_wr_ff & 8'hbf))
    else $error("readback differs from write");
  AST_INIT_MODE: assert property ($stable(operating_mode_select) [*3] |-> init_mode == operating_mode_select[2])
    else $error("init mode wrong");
  AST_LOAD_GATED: assert property (eng_cmd.load_next |-> $past(gate_on) || $past(gate_on, 2))
    else $error("load without any enable");
  AST_LOAD_PULSE: assert property (eng_cmd.load_next |=> !eng_cmd.load_next)
    else $error("load longer than one cycle");
  AST_ONE_SHOT_CLR: assert property (s_one_shot_go |-> ##[1:2] !ctrl_rdata[6])
    else $error("single bit not cleared at start");
  AST_DONE_CLR: assert property (eng_status.tx_done_ok && ctrl_rdata[6] |-> ##[1:2] !ctrl_rdata[6])
    else $error("single bit not cleared on success");
  AST_NO_RETRY: assert property (s_one_shot_go |-> !eng_cmd.allow_retry [*2])
    else $error("retry allowed in one-shot");
endmodule // tcc_monitor

bind tcc_ctrl tcc_monitor mon_u (.clock, .rst_b, .ctrl_wr, .ctrl_wdata, .ctrl_rdata,
  .operating_mode_select, .send_gate_pin, .eng_status, .eng_cmd, .id_filter_active,
  .crystal_drive_enable, .init_mode);

/* File: dv/tcc_eng_model.sv */
// Transmit engine model: queue count, four-cycle frames, optional failure.
// Assumes load_next pulses from tcc_ctrl and bench control of the queue.
`timescale 1ns/1ns
module tcc_eng_model (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  rst_b,
  // Bench control
  input wire logic [3:0]            fill,
  input wire logic                  fill_we,
  input wire logic                  fail_next,
  // Design handshake
  input wire tcc_pkg::tcc_eng_cmd_t eng_cmd,
  output tcc_pkg::tcc_eng_status_t  eng_status,
  output logic [7:0]                sent
);
  import tcc_pkg::*;
  logic [3:0] queue;
  logic [3:0] age;
  logic       busy, retry, st, ok, fl;
  // ==========================================================================
  // Frame engine; the bus counts as busy while a frame is in flight.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {queue, age, busy, retry, st, ok, fl} <= '0;
      sent <= 8'h00;
    end else begin
      {st, ok, fl} <= 3'h0;
      if (fill_we) queue <= fill;
      if (eng_cmd.load_next || retry) begin
        {busy, st, retry, age} <= {3'h6, 4'h0};
      end else if (busy) begin
        age <= age + 4'h1;
        if (age == 4'h3) begin
          busy <= 1'b0;
          if (fail_next) {fl, retry} <= {1'b1, eng_cmd.allow_retry};
          else {ok, queue, sent} <= {1'b1, queue - 4'h1, sent + 8'h01};
        end
      end
    end
  end
  assign eng_status = '{fifo_empty: queue == 4'h0, bus_free: !busy, tx_started: st,
                        tx_done_ok: ok, tx_failed: fl};
endmodule // tcc_eng_model

/* File: dv/tb_top.sv */
// Bench for tcc_ctrl with an engine model on its far side.
// Assumes the register strobe is the only host access path.
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_top;
  import tcc_pkg::*;
  logic            clock = 1'b0, rst_b = 1'b0, ctrl_wr = 1'b0, send_gate_pin = 1'b0;
  logic [7:0]      ctrl_wdata = 8'h00, ctrl_rdata, sent;
  logic [2:0]      operating_mode_select = 3'h0;
  logic [3:0]      fill = 4'h0;
  logic            fill_we = 1'b0, fail_next = 1'b0;
  logic            id_filter_active, crystal_drive_enable, init_mode, divided_clock_pin;
  tcc_eng_status_t eng_status;
  tcc_eng_cmd_t    eng_cmd;
  int              failures = 0, samples_checked = 0, cycles = 0;
  time             t0;
  always #50 clock = ~clock;
  tcc_ctrl dut_u (.clock, .rst_b, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .operating_mode_select,
    .send_gate_pin, .eng_status, .eng_cmd, .id_filter_active, .crystal_drive_enable,
    .init_mode, .divided_clock_pin);
  tcc_eng_model eng_u (.clock, .rst_b, .fill, .fill_we, .fail_next, .eng_cmd, .eng_status,
    .sent);
  // ==========================================================================
  // Access tasks; every strobe lasts exactly one cycle.
  task automatic wr(input logic [7:0] d);
    @(posedge clock);
    {ctrl_wr, ctrl_wdata} <= {1'b1, d};
    @(posedge clock);
    ctrl_wr <= 1'b0;
  endtask
  task automatic load(input logic [3:0] n);
    @(posedge clock);
    {fill_we, fill} <= {1'b1, n};
    @(posedge clock);
    fill_we <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // A hung divider or engine would stall the run, so cap it.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    `CHK({ctrl_rdata, init_mode, crystal_drive_enable, id_filter_active}, 11'h006)
    @(posedge clock);
    operating_mode_select <= 3'h4;
    wr(8'h1c);
    repeat (2) @(negedge clock);
    `CHK({ctrl_rdata, init_mode, crystal_drive_enable, id_filter_active}, 11'h0e5)
    for (int c = 0; c < 4; c++) begin
      wr(8'h1c + c[7:0]);
      repeat (2) @(posedge divided_clock_pin);
      t0 = $time;
      @(posedge divided_clock_pin);
      `CHK($time - t0, 64'd100 << c)
    end
    for (int m = 0; m < 9; m++) begin
      @(posedge clock);
      operating_mode_select <= m[2:0];
      repeat (3) @(negedge clock);
      `CHK(init_mode, m[2] & ~m[3])
    end
    load(4'h3);
    wr(8'h40);
    repeat (40) @(negedge clock);
    `CHK({sent, ctrl_rdata[6]}, 9'h002)
    @(posedge clock);
    send_gate_pin <= 1'b1;
    repeat (40) @(negedge clock);
    `CHK({sent, eng_status.fifo_empty}, 9'h007)
    load(4'h2);
    @(posedge eng_status.tx_started);
    @(posedge clock);
    send_gate_pin <= 1'b0;
    repeat (40) @(negedge clock);
    `CHK(sent, 8'h04)
    @(posedge clock);
    fail_next <= 1'b1;
    wr(8'h60);
    repeat (40) @(negedge clock);
    `CHK({sent, ctrl_rdata[6], eng_status.fifo_empty}, 10'h010)
    wr(8'h40);
    @(posedge eng_status.tx_failed);
    @(posedge clock);
    fail_next <= 1'b0;
    repeat (40) @(negedge clock);
    `CHK({sent, ctrl_rdata[6]}, 9'h00a)
    load(4'h2);
    wr(8'h80);
    repeat (40) @(negedge clock);
    `CHK(sent, 8'h07)
    print_verdict();
  end
endmodule // tb_top
